// File: hdl/pwmcps_params.svh
// Offsets, field positions, reset values and widths of the PWM pair clock front end.
// Assumes inclusion by bare name from the package and the design module.
`ifndef PWMCPS_PARAMS_SVH
`define PWMCPS_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PWMCPS_OFS_SRC_SEL 8'h10
`define PWMCPS_OFS_PSC01 8'h14
`define PWMCPS_OFS_PSC23 8'h18
`define PWMCPS_OFS_PSC45 8'h1c
`define PWMCPS_OFS_RUN_CTL 8'h20

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PWMCPS_SRC01_LSB 0
`define PWMCPS_SRC23_LSB 8
`define PWMCPS_SRC45_LSB 16
`define PWMCPS_SRC_W 3
`define PWMCPS_PSC_W 12
`define PWMCPS_RUN01_BIT 0
`define PWMCPS_RUN23_BIT 2
`define PWMCPS_RUN45_BIT 4

// ----------------------------------------
// Source codes and reset values
// ----------------------------------------
`define PWMCPS_SRC_MODULE_CLK 3'h0
`define PWMCPS_SRC_TIMER_A 3'h1
`define PWMCPS_SRC_TIMER_B 3'h2
`define PWMCPS_SRC_TIMER_C 3'h3
`define PWMCPS_SRC_TIMER_D 3'h4
`define PWMCPS_RST_REG 32'h0000_0000
`define PWMCPS_COUNTER_W 16

`endif

// File: hdl/pwmcps_pkg.sv
// Types shared by the PWM pair clock front end.
// Assumes the params header is on the include path.
`include "pwmcps_params.svh"

package pwmcps_pkg;

  // ----------------------------------------
  // Per-pair settings
  // ----------------------------------------
  typedef struct packed {
    logic [`PWMCPS_SRC_W-1:0] source_select;
    logic [`PWMCPS_PSC_W-1:0] counter_prescale_value;
    logic run_enable;
  } pwmcps_pair_cfg_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } pwmcps_bus_req_s;

endpackage

// File: hdl/pwmcps_top.sv
// PWM pair clock front end: source select, shared 12-bit prescaler and run control per pair.
// Assumes timer overflow inputs are pins from another block and are synchronised here,
// and that the register master is on i_ref_clk.
`timescale 1ns/100ps
`default_nettype none
`include "pwmcps_params.svh"

// Functional notes
// - Each pair has its own 3-bit source field at bits [2:0], [10:8] and [18:16] of the source register.
// - Source code 000 clocks the pair's prescaler from the module input clock.
// - Codes 001 to 100 select overflow of general timer a, b, c or d; other codes are reserved and count nothing.
// - The selected clock is divided by the 12-bit prescale value plus one, so zero passes it undivided.
// - Both channels of a pair share one prescaler and each pair owns a separate prescaler.
// - A low run enable at bit 0, 2 or 4 halts both the pair's counter and its prescaler.
// - Writing one to a run enable starts the pair's prescaler and counter from the selected clock.
module pwmcps_top (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Timer overflow pulses, asynchronous
  input wire logic i_general_timer_a,
  input wire logic i_general_timer_b,
  input wire logic i_general_timer_c,
  input wire logic i_general_timer_d,
  // Per-pair counting ticks and counters, index 0/1/2 = pairs 01/23/45
  output logic [2:0] o_pair_tick,
  output logic [3*`PWMCPS_COUNTER_W-1:0] o_pair_count,
  output logic [2:0] o_pair_running
);

  // ----------------------------------------
  // Timer overflow synchronisers and edge detect
  // ----------------------------------------
  logic [3:0] tmr_meta_q, tmr_sync_q, tmr_last_q;
  logic [3:0] tmr_meta_d, tmr_sync_d, tmr_last_d;
  logic [3:0] tmr_event;

  always_comb begin
    tmr_meta_d = {i_general_timer_d, i_general_timer_c, i_general_timer_b, i_general_timer_a};
    tmr_sync_d = tmr_meta_q;
    tmr_last_d = tmr_sync_q;
    // Rising edge so a long overflow level counts once
    tmr_event = tmr_sync_q & ~tmr_last_q;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      tmr_meta_q <= 4'h0;
      tmr_sync_q <= 4'h0;
      tmr_last_q <= 4'h0;
    end else begin
      tmr_meta_q <= tmr_meta_d;
      tmr_sync_q <= tmr_sync_d;
      tmr_last_q <= tmr_last_d;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  pwmcps_pkg::pwmcps_bus_req_s req;
  pwmcps_pkg::pwmcps_pair_cfg_s [2:0] cfg_q, cfg_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] src_word, run_word;

  always_comb begin
    req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
    cfg_d = cfg_q;
    if (req.wr) begin
      case (req.addr)
        `PWMCPS_OFS_SRC_SEL: begin
          cfg_d[0].source_select = req.wdata[`PWMCPS_SRC01_LSB +: `PWMCPS_SRC_W];
          cfg_d[1].source_select = req.wdata[`PWMCPS_SRC23_LSB +: `PWMCPS_SRC_W];
          cfg_d[2].source_select = req.wdata[`PWMCPS_SRC45_LSB +: `PWMCPS_SRC_W];
        end
        `PWMCPS_OFS_PSC01: cfg_d[0].counter_prescale_value = req.wdata[`PWMCPS_PSC_W-1:0];
        `PWMCPS_OFS_PSC23: cfg_d[1].counter_prescale_value = req.wdata[`PWMCPS_PSC_W-1:0];
        `PWMCPS_OFS_PSC45: cfg_d[2].counter_prescale_value = req.wdata[`PWMCPS_PSC_W-1:0];
        `PWMCPS_OFS_RUN_CTL: begin
          cfg_d[0].run_enable = req.wdata[`PWMCPS_RUN01_BIT];
          cfg_d[1].run_enable = req.wdata[`PWMCPS_RUN23_BIT];
          cfg_d[2].run_enable = req.wdata[`PWMCPS_RUN45_BIT];
        end
        default: begin
        end
      endcase
    end
    // Reserved positions stay zero on read
    src_word = 32'h0;
    src_word[`PWMCPS_SRC01_LSB +: `PWMCPS_SRC_W] = cfg_q[0].source_select;
    src_word[`PWMCPS_SRC23_LSB +: `PWMCPS_SRC_W] = cfg_q[1].source_select;
    src_word[`PWMCPS_SRC45_LSB +: `PWMCPS_SRC_W] = cfg_q[2].source_select;
    run_word = 32'h0;
    run_word[`PWMCPS_RUN01_BIT] = cfg_q[0].run_enable;
    run_word[`PWMCPS_RUN23_BIT] = cfg_q[1].run_enable;
    run_word[`PWMCPS_RUN45_BIT] = cfg_q[2].run_enable;
    // Unmapped reads return zero; read data stands for one cycle only
    rdata_d = 32'h0;
    if (req.rd) begin
      case (req.addr)
        `PWMCPS_OFS_SRC_SEL: rdata_d = src_word;
        `PWMCPS_OFS_PSC01: rdata_d = {20'h0, cfg_q[0].counter_prescale_value};
        `PWMCPS_OFS_PSC23: rdata_d = {20'h0, cfg_q[1].counter_prescale_value};
        `PWMCPS_OFS_PSC45: rdata_d = {20'h0, cfg_q[2].counter_prescale_value};
        `PWMCPS_OFS_RUN_CTL: rdata_d = run_word;
        default: rdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_q <= '0;
      rdata_q <= `PWMCPS_RST_REG;
    end else begin
      cfg_q <= cfg_d;
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;

  // ----------------------------------------
  // Per-pair source select, prescaler and counter
  // ----------------------------------------
  logic [2:0] src_tick;
  logic [2:0][`PWMCPS_PSC_W-1:0] psc_q, psc_d;
  logic [2:0][`PWMCPS_COUNTER_W-1:0] cnt_q, cnt_d;
  logic [2:0] tick_q, tick_d;
  logic [2:0] run_q, run_d;

  always_comb begin
    for (int p = 0; p < 3; p++) begin
      case (cfg_q[p].source_select)
        `PWMCPS_SRC_MODULE_CLK: src_tick[p] = 1'b1;
        `PWMCPS_SRC_TIMER_A: src_tick[p] = tmr_event[0];
        `PWMCPS_SRC_TIMER_B: src_tick[p] = tmr_event[1];
        `PWMCPS_SRC_TIMER_C: src_tick[p] = tmr_event[2];
        `PWMCPS_SRC_TIMER_D: src_tick[p] = tmr_event[3];
        // Reserved codes: nothing counts
        default: src_tick[p] = 1'b0;
      endcase
      psc_d[p] = psc_q[p];
      cnt_d[p] = cnt_q[p];
      tick_d[p] = 1'b0;
      run_d[p] = cfg_q[p].run_enable;
      if (!cfg_q[p].run_enable) begin
        // Halt keeps the counter value; prescaler restarts from zero on next start
        psc_d[p] = '0;
      end else if (src_tick[p]) begin
        if (psc_q[p] >= cfg_q[p].counter_prescale_value) begin
          psc_d[p] = '0;
          tick_d[p] = 1'b1;
          cnt_d[p] = cnt_q[p] + 16'h1;
        end else begin
          psc_d[p] = psc_q[p] + 12'h1;
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      psc_q <= '0;
      cnt_q <= '0;
      tick_q <= 3'h0;
      run_q <= 3'h0;
    end else begin
      psc_q <= psc_d;
      cnt_q <= cnt_d;
      tick_q <= tick_d;
      run_q <= run_d;
    end
  end

  assign o_pair_tick = tick_q;
  assign o_pair_count = {cnt_q[2], cnt_q[1], cnt_q[0]};
  assign o_pair_running = run_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_SRC_FIELD_LAYOUT: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_wr && i_addr == `PWMCPS_OFS_SRC_SEL) |=> cfg_q[1].source_select == $past(i_wdata[10:8]))
    else $error("Pair 23 source field not taken from bits 10:8");
  AST_MODULE_CLK_UNDIVIDED: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (cfg_q[0].run_enable && cfg_q[0].source_select == 3'h0 && cfg_q[0].counter_prescale_value == 12'h0
     && !(i_wr)) |=> tick_q[0])
    else $error("Module clock source with zero prescale did not tick every cycle");
  AST_RESERVED_SRC_IDLE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (cfg_q[2].source_select > 3'h4) |=> !tick_q[2])
    else $error("Reserved source code produced a tick");
  AST_TIMER_A_TICK: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (cfg_q[1].run_enable && cfg_q[1].source_select == 3'h1 && cfg_q[1].counter_prescale_value == 12'h0
     && tmr_event[0]) |=> tick_q[1])
    else $error("Timer a overflow did not tick pair 23");
  AST_PSC_WRAP: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    tick_q[0] |-> $past(psc_q[0]) == $past(cfg_q[0].counter_prescale_value))
    else $error("Pair 01 tick not at prescale terminal count");
  AST_PSC_BOUND: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (cfg_q[2].run_enable && $stable(cfg_q[2].counter_prescale_value)) |-> psc_q[2] <= cfg_q[2].counter_prescale_value)
    else $error("Pair 45 prescaler beyond its value");
  AST_HALT: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !cfg_q[0].run_enable |=> (!tick_q[0] && $stable(cnt_q[0]) && psc_q[0] == 12'h0))
    else $error("Halted pair 01 still counting");
  AST_START: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_wr && i_addr == `PWMCPS_OFS_RUN_CTL && i_wdata[4]) |=> ##1 o_pair_running[2])
    else $error("Run enable write did not start pair 45");
  AST_RESERVED_READ: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_rd && i_addr == `PWMCPS_OFS_RUN_CTL) |=> o_rdata[31:5] == 27'h0 && !o_rdata[1] && !o_rdata[3])
    else $error("Reserved run control bits read nonzero");

  // ----------------------------------------
  // Checks on field layout and read-back
  // ----------------------------------------
  AST_SRC01_FIELD: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_wr && i_addr == `PWMCPS_OFS_SRC_SEL) |=> cfg_q[0].source_select == $past(i_wdata[2:0]))
    else $error("Pair 01 source field not taken from bits 2:0");
  AST_SRC45_FIELD: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_wr && i_addr == `PWMCPS_OFS_SRC_SEL) |=> cfg_q[2].source_select == $past(i_wdata[18:16]))
    else $error("Pair 45 source field not taken from bits 18:16");
  AST_SRC_HOLD: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !(i_wr && i_addr == `PWMCPS_OFS_SRC_SEL) |=> $stable(cfg_q[0].source_select))
    else $error("Pair 01 source field changed without a source write");
  AST_PSC_SEPARATE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_wr && i_addr == `PWMCPS_OFS_PSC01) |=>
      ($stable(cfg_q[1].counter_prescale_value) && $stable(cfg_q[2].counter_prescale_value)))
    else $error("Pair 01 prescale write reached another pair");
  AST_RESERVED_SRC_READ: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_rd && i_addr == `PWMCPS_OFS_SRC_SEL) |=>
      (o_rdata[31:19] == 13'h0 && o_rdata[15:11] == 5'h0 && o_rdata[7:3] == 5'h0))
    else $error("Reserved source select bits read nonzero");
  AST_RESERVED_PSC_READ: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_rd && (i_addr == `PWMCPS_OFS_PSC01 || i_addr == `PWMCPS_OFS_PSC23 || i_addr == `PWMCPS_OFS_PSC45))
      |=> o_rdata[31:12] == 20'h0)
    else $error("Reserved prescale bits read nonzero");

  // ----------------------------------------
  // Checks on source selection and division
  // ----------------------------------------
  AST_MODULE_CLK_PAIR23: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (cfg_q[1].run_enable && cfg_q[1].source_select == 3'h0 && cfg_q[1].counter_prescale_value == 12'h0)
      |=> tick_q[1])
    else $error("Module clock source with zero prescale did not tick pair 23");
  AST_MODULE_CLK_PAIR45: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (cfg_q[2].run_enable && cfg_q[2].source_select == 3'h0 && cfg_q[2].counter_prescale_value == 12'h0)
      |=> tick_q[2])
    else $error("Module clock source with zero prescale did not tick pair 45");
  AST_RESERVED_CODE_PAIR01: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (cfg_q[0].source_select > 3'h4) |=> !tick_q[0])
    else $error("Reserved source code produced a tick on pair 01");
  AST_TIMER_B_ONLY: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (cfg_q[2].run_enable && cfg_q[2].source_select == 3'h2 && !tmr_event[1]) |=> !tick_q[2])
    else $error("Pair 45 ticked with timer b selected but no timer b overflow");
  AST_TIMER_D_ONLY: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (cfg_q[2].run_enable && cfg_q[2].source_select == 3'h4 && !tmr_event[3]) |=> !tick_q[2])
    else $error("Pair 45 ticked with timer d selected but no timer d overflow");
  AST_PSC_STEP: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (cfg_q[1].run_enable && src_tick[1] && psc_q[1] < cfg_q[1].counter_prescale_value)
      |=> (psc_q[1] == $past(psc_q[1]) + 12'h1 && !tick_q[1]))
    else $error("Pair 23 prescaler did not step by one below its value");
  AST_PSC_WAIT: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (cfg_q[1].run_enable && !src_tick[1]) |=> ($stable(psc_q[1]) && !tick_q[1]))
    else $error("Pair 23 prescaler moved without a source tick");
  AST_COUNT_ON_TICK: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    tick_q[1] |-> cnt_q[1] == $past(cnt_q[1]) + 16'h1)
    else $error("Pair 23 counter did not step with its tick");
  AST_COUNT_ONLY_ON_TICK: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !tick_q[2] |-> $stable(cnt_q[2]))
    else $error("Pair 45 counter moved without its tick");

  // ----------------------------------------
  // Checks on run control
  // ----------------------------------------
  AST_HALT_PAIR23: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !cfg_q[1].run_enable |=> (!tick_q[1] && $stable(cnt_q[1]) && psc_q[1] == 12'h0))
    else $error("Halted pair 23 still counting");
  AST_HALT_PAIR45: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !cfg_q[2].run_enable |=> (!tick_q[2] && $stable(cnt_q[2]) && psc_q[2] == 12'h0))
    else $error("Halted pair 45 still counting");
  AST_RUNNING_COPY: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (o_pair_running[0] == $past(cfg_q[0].run_enable) && o_pair_running[1] == $past(cfg_q[1].run_enable)
     && o_pair_running[2] == $past(cfg_q[2].run_enable)))
    else $error("Running flags do not follow the run enables");
  AST_START_PAIR01: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_wr && i_addr == `PWMCPS_OFS_RUN_CTL && i_wdata[0]) |=> ##1 o_pair_running[0])
    else $error("Run enable write did not start pair 01");
  AST_START_PAIR23: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_wr && i_addr == `PWMCPS_OFS_RUN_CTL && i_wdata[2]) |=> ##1 o_pair_running[1])
    else $error("Run enable write did not start pair 23");
  AST_TICK_NEEDS_RUN: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    tick_q[0] |-> $past(cfg_q[0].run_enable))
    else $error("Pair 01 ticked while not enabled");
  AST_PSC_RESTART: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $rose(cfg_q[2].run_enable) |-> psc_q[2] == 12'h0)
    else $error("Pair 45 prescaler not at zero when started");

endmodule
`default_nettype wire

// File: tb/tb_pwmcps_top.sv
// Self-checking bench for the PWM pair clock front end.
// Assumes the design package and header are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_pwmcps_top;
  logic i_ref_clk;
  logic i_rst;
  logic [7:0] i_addr;
  logic [31:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic [31:0] o_rdata;
  logic [3:0] tmr;
  logic [2:0] o_pair_tick;
  logic [47:0] o_pair_count;
  logic [2:0] o_pair_running;
  int err_count;
  int comparisons;
  int tick_n[3];

  pwmcps_top pwmcps_top_i (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_general_timer_a(tmr[0]), .i_general_timer_b(tmr[1]),
    .i_general_timer_c(tmr[2]), .i_general_timer_d(tmr[3]),
    .o_pair_tick(o_pair_tick), .o_pair_count(o_pair_count), .o_pair_running(o_pair_running)
  );

  initial begin
    i_ref_clk = 1'b0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end

  always @(posedge i_ref_clk) begin
    for (int p = 0; p < 3; p++) begin
      if (o_pair_tick[p] === 1'b1) tick_n[p]++;
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask

  task automatic wrap_up;
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    logic [31:0] d;
    logic [31:0] m;
    for (int i = 0; i < 5; i++) begin
      m = (i == 0) ? 32'h0007_0707 : ((i == 4) ? 32'h0000_0015 : 32'h0000_0fff);
      rd(8'h10 + 8'(4 * i), d);
      chk(d, 32'h0000_0000);
      wr(8'h10 + 8'(4 * i), 32'hffff_ffff);
      rd(8'h10 + 8'(4 * i), d);
      chk(d, m);
      wr(8'h10 + 8'(4 * i), 32'h0000_0000);
    end
    wr(8'h24, 32'hffff_ffff);
    rd(8'h24, d);
    chk(d, 32'h0000_0000);
  endtask

  task automatic t_modclk;
    int s[3];
    logic [47:0] c;
    wr(8'h14, 32'h0000_0000);
    wr(8'h18, 32'h0000_0002);
    wr(8'h1c, 32'h0000_0011);
    wr(8'h10, 32'h0000_0000);
    wr(8'h20, 32'h0000_0015);
    cyc(10);
    chk(32'(o_pair_running), 32'h7);
    s = tick_n;
    c = o_pair_count;
    cyc(36);
    chk(tick_n[0] - s[0], 36);
    chk(tick_n[1] - s[1], 12);
    chk(tick_n[2] - s[2], 2);
    chk(32'(o_pair_count[15:0] - c[15:0]), 36);
    chk(32'(o_pair_count[31:16] - c[31:16]), 12);
    chk(32'(o_pair_count[47:32] - c[47:32]), 2);
    wr(8'h20, 32'h0000_0000);
    cyc(4);
    s = tick_n;
    c = o_pair_count;
    cyc(20);
    chk(tick_n[0] + tick_n[1] + tick_n[2] - s[0] - s[1] - s[2], 0);
    chk(o_pair_count[31:0], c[31:0]);
    chk(32'(o_pair_count[47:32]), 32'(c[47:32]));
    chk(32'(o_pair_running), 32'h0);
  endtask

  // Timer j gets 2*(j+1) pulses; divide by two leaves j+1 ticks on pair 45
  // Pair 23 follows timer a undivided, so it sees exactly two ticks
  task automatic t_timer;
    int s;
    int s1;
    wr(8'h18, 32'h0000_0000);
    for (int code = 1; code < 8; code++) begin
      wr(8'h1c, 32'h0000_0001);
      wr(8'h10, (32'(code) << 16) | 32'h0000_0100);
      wr(8'h20, 32'h0000_0014);
      cyc(4);
      s = tick_n[2];
      s1 = tick_n[1];
      for (int j = 0; j < 4; j++) begin
        repeat (2 * (j + 1)) begin
          @(posedge i_ref_clk);
          tmr <= 4'h1 << j;
          repeat (3) @(posedge i_ref_clk);
          tmr <= 4'h0;
          repeat (2) @(posedge i_ref_clk);
        end
      end
      cyc(6);
      chk(tick_n[2] - s, (code <= 4) ? code : 0);
      chk(tick_n[1] - s1, 2);
      wr(8'h20, 32'h0000_0000);
    end
  endtask

  initial begin
    #200000;
    err_count++;
    wrap_up;
  end

  initial begin
    i_rst = 1'b1;
    i_addr = 8'h00;
    i_wdata = 32'h0000_0000;
    i_wr = 1'b0;
    i_rd = 1'b0;
    tmr = 4'h0;
    repeat (12) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    t_regs;
    t_modclk;
    t_timer;
    wrap_up;
  end
endmodule
`default_nettype wire
